// >>> brcd_pkg.sv
// Constants and types shared by the boot region command decoder
package brcd_pkg;

  // Address field widths
  localparam int BLOCK_W = 10;
  localparam int PAGE_W = 6;
  localparam int FSA_W = 2;
  localparam int BSA_W = 4;
  localparam int BSC_W = 2;
  localparam int IDX_W = 10;

  // Command codes written into the boot region
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_LOAD = 16'h00E0;
  localparam logic [15:0] CMD_LOAD2 = 16'h0000;
  localparam logic [15:0] CMD_ID = 16'h0090;

  // Boot region windows and boot code RAM layout
  localparam logic [15:0] BOOT_LO_END = 16'h01FF;
  localparam logic [15:0] BOOT_HI_BASE = 16'h8000;
  localparam logic [15:0] BOOT_HI_END = 16'h800F;
  localparam int BOOT_WORDS = 528;
  localparam logic [IDX_W-1:0] BOOT_HI_IDX = 10'h200;

  // Identification read offsets
  localparam logic [15:0] ID_OFS_MFR = 16'h0000;
  localparam logic [15:0] ID_OFS_DEV = 16'h0001;
  localparam logic [15:0] ID_OFS_WP = 16'h0002;

  // APB byte offsets
  localparam logic [7:0] REG_FLASH_ADDR = 8'h00;
  localparam logic [7:0] REG_BUF_SEL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BOOT_IDX = 8'h0C;
  localparam logic [7:0] REG_BOOT_DATA = 8'h10;

  // Field positions
  localparam int FA_BLOCK_LSB = 0;
  localparam int FA_PAGE_LSB = 16;
  localparam int FA_FSA_LSB = 24;
  localparam int BS_BSA_LSB = 0;
  localparam int BS_BSC_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_ID = 1;
  localparam int ST_PEND = 2;

  // Values after reset
  localparam logic [BLOCK_W-1:0] BLOCK_RST = 10'h000;
  localparam logic [PAGE_W-1:0] PAGE_RST = 6'h00;
  localparam logic [FSA_W-1:0] FSA_RST = 2'h0;
  localparam logic [BSA_W-1:0] BSA_RST = 4'h0;
  localparam logic [BSC_W-1:0] BSC_RST = 2'h0;
  localparam logic [IDX_W-1:0] IDX_RST = 10'h000;

  // Asynchronous host bus pins
  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic [15:0] addr;
    logic [15:0] dq;
  } brcd_host_t;

  localparam brcd_host_t HOST_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1,
                                       addr: 16'h0000, dq: 16'h0000};

  // Ordinary write passed to buffer memory or registers
  typedef struct packed {
    logic stb;
    logic [15:0] addr;
    logic [15:0] data;
  } brcd_bufwr_t;

  typedef enum logic [2:0] {
    CS_READY = 3'b001,
    CS_PEND = 3'b010,
    CS_ID = 3'b100
  } brcd_cmd_st_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b01,
    LD_BUSY = 2'b10
  } brcd_ld_st_t;

endpackage : brcd_pkg

// >>> brcd_page_loader.sv
// Page load sequencer: busy from start until the flash side reports done
`timescale 1ns/10ps
`default_nettype none
module brcd_page_loader (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic flashDone,
  output logic busy_r,
  output logic loadReq_r,
  output logic finish_r
);
  import brcd_pkg::*;

  brcd_ld_st_t st_r;

  // Sequencer; abort wins so a reset command never leaves a stale load
  always_ff @(posedge sys_clk) begin
    if (rst || abort) begin
      st_r <= LD_IDLE;
      busy_r <= 1'b0;
      loadReq_r <= 1'b0;
      finish_r <= 1'b0;
    end else begin
      loadReq_r <= 1'b0;
      finish_r <= 1'b0;
      case (st_r)
        LD_IDLE: begin
          if (start) begin
            st_r <= LD_BUSY;
            busy_r <= 1'b1;
            loadReq_r <= 1'b1;
          end
        end
        LD_BUSY: begin
          if (flashDone) begin
            st_r <= LD_IDLE;
            busy_r <= 1'b0;
            finish_r <= 1'b1;
          end
        end
        default: begin
          st_r <= LD_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

endmodule : brcd_page_loader
`default_nettype wire

// >>> brcd_top.sv
// Boot region command decoder with APB register access
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
//Function
// - Only writes landing in the boot region windows count as command cycles.
// - A boot region read returns boot code RAM only while no command is in effect.
// - A write outside the boot region is passed on as an ordinary buffer write.
// - A command runs only after all of its cycles have been written.
// - A wrong code in the boot region drops any partial sequence back to ready.
// - Command sequences use asynchronous reads and writes only.
// - Writing the reset code restores the flash address, buffer select and boot index defaults, except while a load code is pending.
// - The page load is the reset-free pair load code then zero, copying one page.
// - A page load uses only the block and page addresses.
// - Each finished page load advances the page address by one, unless a reset code or a software flash address write lands in the same cycle.
// - The page advance wraps inside the block and never touches the block address.
// - Block and page addresses come out of reset as zero.
// - After the identification code, reads give maker, part and protect status.
// - Any write strobe except another identification code ends identification mode.
module brcd_top #(
  parameter logic [15:0] MFR_ID = 16'h0A5A, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h0123 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  input wire brcd_pkg::brcd_host_t hostPins,
  output logic [15:0] hostDqOut_r,
  output logic hostDqOe_r,
  input wire logic [15:0] bufRdData,
  input wire logic [15:0] writeProtStatus,
  output brcd_pkg::brcd_bufwr_t bufWr_r,
  input wire logic flashDone,
  output logic loadReq_r,
  output logic [brcd_pkg::BLOCK_W-1:0] loadBlock_r,
  output logic [brcd_pkg::PAGE_W-1:0] loadPage_r,
  output logic softRst_r
);
  import brcd_pkg::*;

  brcd_host_t s1_r, s2_r, s3_r;
  brcd_cmd_st_t st_r, stNxt;
  logic [BLOCK_W-1:0] blockAddr_r;
  logic [PAGE_W-1:0] pageAddr_r, pageInc;
  logic [FSA_W-1:0] fsa_r;
  logic [BSA_W-1:0] bsa_r;
  logic [BSC_W-1:0] bsc_r;
  logic [IDX_W-1:0] idx_r;
  logic [15:0] boot_code_ram [BOOT_WORDS];
  logic [15:0] bootWord, rdMux, statusWord;
  logic wrEvent, bootWr, outWr, rdActive, rdStart, bootRdStart;
  logic [15:0] wrAddr, wrData;
  logic acceptNew, startLoad, doReset;
  logic loadBusy, loadFinish;
  logic apbAccess, apbWr, apbAddrWr, mapped;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  function automatic logic isBoot(input logic [15:0] a);
    isBoot = (a <= BOOT_LO_END) || (a >= BOOT_HI_BASE && a <= BOOT_HI_END);
  endfunction : isBoot

  function automatic logic [IDX_W-1:0] bootIdx(input logic [15:0] a);
    if (a <= BOOT_LO_END) begin
      bootIdx = a[IDX_W-1:0];
    end else begin
      bootIdx = BOOT_HI_IDX | {6'h00, a[3:0]};
    end
  endfunction : bootIdx

  // Two-flop pin synchroniser plus one history stage for edges
  // Strobes are sampled as plain levels: no burst clock is used
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= HOST_IDLE;
      s2_r <= HOST_IDLE;
      s3_r <= HOST_IDLE;
    end else begin
      s1_r <= hostPins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Write ends on the strobe's rising edge; take address and data from before it
  assign wrEvent = !s3_r.weN && s2_r.weN && !s3_r.ceN;
  assign wrAddr = s3_r.addr;
  assign wrData = s3_r.dq;
  assign bootWr = wrEvent && isBoot(wrAddr);
  assign outWr = wrEvent && !isBoot(wrAddr);
  assign rdActive = !s2_r.ceN && !s2_r.oeN && s2_r.weN;
  assign rdStart = rdActive && (s3_r.ceN || s3_r.oeN || !s3_r.weN);
  assign bootRdStart = rdStart && isBoot(s2_r.addr);

  // New commands are refused while a page load runs, except reset
  assign acceptNew = bootWr && (st_r != CS_PEND) && !loadBusy;
  assign doReset = bootWr && (wrData == CMD_RESET) && (st_r != CS_PEND);

  // Command sequencer
  always_comb begin
    stNxt = st_r;
    startLoad = 1'b0;
    case (st_r)
      CS_READY, CS_ID: begin
        if (wrEvent) begin
          stNxt = CS_READY;
        end
        if (acceptNew) begin
          case (wrData)
            CMD_LOAD: stNxt = CS_PEND;
            CMD_ID: stNxt = CS_ID;
            default: stNxt = CS_READY;
          endcase
        end
      end
      CS_PEND: begin
        if (bootWr) begin
          startLoad = (wrData == CMD_LOAD2);
          stNxt = CS_READY;
        end else if (bootRdStart) begin
          stNxt = CS_READY;
        end
      end
      default: stNxt = CS_READY;
    endcase
    if (doReset) begin
      stNxt = CS_READY;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= CS_READY;
    end else begin
      st_r <= stNxt;
    end
  end

  brcd_page_loader u_loader (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(startLoad),
    .abort(doReset),
    .flashDone(flashDone),
    .busy_r(loadBusy),
    .loadReq_r(loadReq_r),
    .finish_r(loadFinish)
  );

  // Snapshot of the load target; sector and buffer fields play no part
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loadBlock_r <= BLOCK_RST;
      loadPage_r <= PAGE_RST;
    end else if (startLoad) begin
      loadBlock_r <= blockAddr_r;
      loadPage_r <= pageAddr_r;
    end
  end

  // APB slave: one wait state so read data comes from a flop
  assign apbAccess = psel && penable;
  assign apbWr = apbAccess && pwrite && pready_r;
  assign apbAddrWr = apbWr && (paddr == REG_FLASH_ADDR);
  assign mapped = (paddr == REG_FLASH_ADDR) || (paddr == REG_BUF_SEL) ||
                  (paddr == REG_STATUS) || (paddr == REG_BOOT_IDX) ||
                  (paddr == REG_BOOT_DATA);

  // Page counter is only PAGE_W wide, so it wraps inside the block
  assign pageInc = pageAddr_r + 6'h01;

  // Flash address; reset command beats software, software beats the advance
  always_ff @(posedge sys_clk) begin
    if (rst || doReset) begin
      blockAddr_r <= BLOCK_RST;
      pageAddr_r <= PAGE_RST;
      fsa_r <= FSA_RST;
    end else if (apbAddrWr) begin
      blockAddr_r <= pwdata[FA_BLOCK_LSB +: BLOCK_W];
      pageAddr_r <= pwdata[FA_PAGE_LSB +: PAGE_W];
      fsa_r <= pwdata[FA_FSA_LSB +: FSA_W];
    end else if (loadFinish) begin
      pageAddr_r <= pageInc;
    end
  end

  // Buffer selection, kept for software only
  always_ff @(posedge sys_clk) begin
    if (rst || doReset) begin
      bsa_r <= BSA_RST;
      bsc_r <= BSC_RST;
    end else if (apbWr && paddr == REG_BUF_SEL) begin
      bsa_r <= pwdata[BS_BSA_LSB +: BSA_W];
      bsc_r <= pwdata[BS_BSC_LSB +: BSC_W];
    end
  end

  // Boot RAM index auto-advances on each data write for fast fill
  always_ff @(posedge sys_clk) begin
    if (rst || doReset) begin
      idx_r <= IDX_RST;
    end else if (apbWr && paddr == REG_BOOT_IDX) begin
      idx_r <= pwdata[IDX_W-1:0];
    end else if (apbWr && paddr == REG_BOOT_DATA) begin
      idx_r <= idx_r + 10'h001;
    end
  end

  // Boot code storage, filled by software; out-of-range writes dropped
  always_ff @(posedge sys_clk) begin
    if (apbWr && paddr == REG_BOOT_DATA && idx_r < IDX_W'(BOOT_WORDS)) begin
      boot_code_ram[idx_r] <= pwdata[15:0];
    end
  end

  assign statusWord = {13'h0000, st_r == CS_PEND, st_r == CS_ID, loadBusy};

  // APB answer path
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= apbAccess && !pready_r;
      pslverr_r <= apbAccess && !pready_r && !mapped;
      prdata_r <= 32'h00000000;
      if (apbAccess && !pready_r && !pwrite) begin
        case (paddr)
          REG_FLASH_ADDR: begin
            prdata_r[FA_BLOCK_LSB +: BLOCK_W] <= blockAddr_r;
            prdata_r[FA_PAGE_LSB +: PAGE_W] <= pageAddr_r;
            prdata_r[FA_FSA_LSB +: FSA_W] <= fsa_r;
          end
          REG_BUF_SEL: begin
            prdata_r[BS_BSA_LSB +: BSA_W] <= bsa_r;
            prdata_r[BS_BSC_LSB +: BSC_W] <= bsc_r;
          end
          REG_STATUS: prdata_r[15:0] <= statusWord;
          REG_BOOT_IDX: prdata_r[IDX_W-1:0] <= idx_r;
          REG_BOOT_DATA: begin
            if (idx_r < IDX_W'(BOOT_WORDS)) begin
              prdata_r[15:0] <= boot_code_ram[idx_r];
            end
          end
          default: prdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign bootWord = boot_code_ram[bootIdx(s2_r.addr)];

  // Host read mux; protect status is for the block software last set
  always_comb begin
    rdMux = bufRdData;
    if (isBoot(s2_r.addr)) begin
      if (st_r == CS_ID) begin
        case (s2_r.addr)
          ID_OFS_MFR: rdMux = MFR_ID;
          ID_OFS_DEV: rdMux = DEV_ID;
          ID_OFS_WP: rdMux = writeProtStatus;
          default: rdMux = 16'h0000;
        endcase
      end else if (st_r == CS_PEND || loadBusy) begin
        rdMux = statusWord;
      end else begin
        rdMux = bootWord;
      end
    end
  end

  // Host data pins and ordinary write strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hostDqOut_r <= 16'h0000;
      hostDqOe_r <= 1'b0;
      bufWr_r <= '{stb: 1'b0, addr: 16'h0000, data: 16'h0000};
      softRst_r <= 1'b0;
    end else begin
      hostDqOut_r <= rdMux;
      hostDqOe_r <= rdActive;
      bufWr_r.stb <= outWr;
      if (outWr) begin
        bufWr_r.addr <= wrAddr;
        bufWr_r.data <= wrData;
      end
      softRst_r <= doReset;
    end
  end

  cmd_region_a: assert property (
    outWr && st_r == CS_READY |=> st_r == CS_READY && !loadReq_r)
    else $error("outside write changed command state");
  boot_read_a: assert property (
    rdActive && isBoot(s2_r.addr) && st_r == CS_READY && !loadBusy
    |=> hostDqOut_r == $past(bootWord))
    else $error("boot read did not return boot RAM");
  buf_write_a: assert property (
    outWr |=> bufWr_r.stb && bufWr_r.addr == $past(wrAddr))
    else $error("outside write not passed on");
  load_start_a: assert property (
    st_r == CS_PEND && bootWr && wrData == CMD_LOAD2 |=> loadBusy && loadReq_r)
    else $error("page load did not start");
  abandon_seq_a: assert property (
    st_r == CS_PEND && bootWr && wrData != CMD_LOAD2 |=> st_r == CS_READY && !loadBusy)
    else $error("bad second cycle not abandoned");
  reset_cmd_a: assert property (
    doReset |=> blockAddr_r == BLOCK_RST && pageAddr_r == PAGE_RST && softRst_r)
    else $error("reset command did not restore defaults");
  load_addr_a: assert property (
    startLoad |=> loadBlock_r == $past(blockAddr_r) && loadPage_r == $past(pageAddr_r))
    else $error("load target wrong");
  page_inc_a: assert property (
    loadFinish && !doReset && !apbAddrWr
    |=> pageAddr_r == $past(pageInc) && blockAddr_r == $past(blockAddr_r))
    else $error("page advance wrong");
  rst_default_a: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    rst |=> blockAddr_r == BLOCK_RST && pageAddr_r == PAGE_RST)
    else $error("addresses not zero after reset");
  id_read_a: assert property (
    st_r == CS_ID && rdActive && s2_r.addr == ID_OFS_DEV |=> hostDqOut_r == DEV_ID)
    else $error("device code not returned");
  id_end_a: assert property (
    st_r == CS_ID && wrEvent && !(bootWr && wrData == CMD_ID) |=> st_r != CS_ID)
    else $error("write strobe did not end identification");
  pend_hold_a: assert property (
    st_r == CS_PEND && !bootWr && !bootRdStart |=> st_r == CS_PEND)
    else $error("pending code lost early");
  busy_span_a: assert property (
    loadBusy && !flashDone && !doReset |=> loadBusy && !loadFinish)
    else $error("busy dropped before copy done");

endmodule : brcd_top
`default_nettype wire

// >>> brcd_host_model.sv
// Host processor model for the asynchronous boot bus
`timescale 1ns/10ps
`default_nettype none
module brcd_host_model (
  input wire logic sys_clk,
  input wire logic [15:0] hostDqOut_r,
  input wire logic hostDqOe_r,
  output brcd_pkg::brcd_host_t hostPins
);
  import brcd_pkg::*;
  logic [15:0] rdData;
  logic rdOe;

  // Bus idles with all strobes high
  initial hostPins = HOST_IDLE;

  // Asynchronous write; widths well above the two-flop sync delay
  task automatic hostWrite(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    hostPins.ceN <= 1'b0;
    hostPins.addr <= a;
    hostPins.dq <= d;
    repeat (3) @(posedge sys_clk);
    hostPins.weN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    hostPins.weN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    hostPins.ceN <= 1'b1;
    hostPins.dq <= ~d; // Released bus must not show a stale word
    repeat (4) @(posedge sys_clk);
  endtask : hostWrite

  // Asynchronous read; answer sampled once the 3-cycle latency is over
  task automatic hostRead(input logic [15:0] a);
    @(posedge sys_clk);
    hostPins.ceN <= 1'b0;
    hostPins.oeN <= 1'b0;
    hostPins.addr <= a;
    hostPins.dq <= ~hostPins.dq;
    repeat (6) @(posedge sys_clk);
    rdData = hostDqOut_r;
    rdOe = hostDqOe_r;
    hostPins.ceN <= 1'b1;
    hostPins.oeN <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : hostRead
endmodule : brcd_host_model
`default_nettype wire

// >>> test_boot_region_command_decoder.sv
// Self-checking bench for the boot region command decoder
`timescale 1ns/10ps
`default_nettype none
module test_boot_region_command_decoder;
  import brcd_pkg::*;
  localparam logic [15:0] MFR = 16'h3C3C; // Arbitrary value
  localparam logic [15:0] DEV = 16'h0456; // Arbitrary value
  localparam logic [15:0] WP = 16'h0001;
  localparam logic [15:0] BUFD = 16'hC0DE;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, hostDqOe_r, loadReq_r, softRst_r, rdErr;
  logic flashDone = 1'b0;
  logic [15:0] hostDqOut_r;
  brcd_host_t hostPins;
  brcd_bufwr_t bufWr_r;
  logic [BLOCK_W-1:0] loadBlock_r;
  logic [PAGE_W-1:0] loadPage_r;
  logic [31:0] rd;
  logic [31:0] loadCnt = 32'h0;
  logic [31:0] rstCnt = 32'h0;
  logic [31:0] stbCnt = 32'h0;
  int cyc = 0;
  int bad_count = 0;
  int checks_done = 0;

  // Free-running 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  brcd_top #(.MFR_ID(MFR), .DEV_ID(DEV)) uut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .hostPins(hostPins), .hostDqOut_r(hostDqOut_r),
    .hostDqOe_r(hostDqOe_r), .bufRdData(BUFD), .writeProtStatus(WP), .bufWr_r(bufWr_r),
    .flashDone(flashDone), .loadReq_r(loadReq_r), .loadBlock_r(loadBlock_r),
    .loadPage_r(loadPage_r), .softRst_r(softRst_r)
  );

  brcd_host_model host (
    .sys_clk(sys_clk), .hostDqOut_r(hostDqOut_r), .hostDqOe_r(hostDqOe_r),
    .hostPins(hostPins)
  );

  // Pulse counters; watchdog cuts a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (loadReq_r === 1'b1) loadCnt <= loadCnt + 1;
    if (softRst_r === 1'b1) rstCnt <= rstCnt + 1;
    if (bufWr_r.stb === 1'b1) stbCnt <= stbCnt + 1;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chkReg

  // Host read data must come with the output enable high
  task automatic chkHost(input logic [15:0] exp);
    checks_done++;
    if (host.rdData !== exp || host.rdOe !== 1'b1) begin
      bad_count++;
      $display("FAIL t=%0t host read %h oe %b expected %h", $time, host.rdData, host.rdOe, exp);
    end
  endtask : chkHost

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready_r !== 1'b1);
    rd = prdata_r;
    rdErr = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
    apbXfer(1'b0, a, 32'h0);
    chkReg(rd, exp);
  endtask : rdReg

  task automatic rdHost(input logic [15:0] a, input logic [15:0] exp);
    host.hostRead(a);
    chkHost(exp);
  endtask : rdHost

  // Flash side reports the page copied
  task automatic donePulse();
    @(posedge sys_clk);
    flashDone <= 1'b1;
    @(posedge sys_clk);
    flashDone <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : donePulse

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rdReg(REG_FLASH_ADDR, 32'h0);
    rdReg(REG_STATUS, 32'h0);
    apbXfer(1'b0, 8'h14, 32'h0);
    chkReg({31'h0, rdErr}, 32'h1);
    apbXfer(1'b1, REG_BOOT_IDX, 32'h0);
    apbXfer(1'b1, REG_BOOT_DATA, 32'h1234);
    apbXfer(1'b1, REG_BOOT_DATA, 32'h5678);
    apbXfer(1'b1, REG_BOOT_IDX, {22'h0, BOOT_HI_IDX});
    apbXfer(1'b1, REG_BOOT_DATA, 32'h8A8A);
    rdHost(16'h0000, 16'h1234);
    rdHost(16'h0001, 16'h5678);
    rdHost(BOOT_HI_BASE, 16'h8A8A);
    rdHost(16'h0400, BUFD);
    // Codes just outside the windows are plain buffer writes
    host.hostWrite(16'h0200, CMD_RESET);
    host.hostWrite(16'h8010, CMD_ID);
    chkReg(stbCnt, 32'h2);
    chkReg({bufWr_r.addr, bufWr_r.data}, {16'h8010, CMD_ID});
    chkReg(rstCnt, 32'h0);
    rdReg(REG_STATUS, 32'h0);
    // Page load at the last page of a block, with ignored fields set
    apbXfer(1'b1, REG_FLASH_ADDR, 32'h033F_0005);
    apbXfer(1'b1, REG_BUF_SEL, 32'h0000_030F);
    host.hostWrite(16'h0010, CMD_LOAD);
    rdReg(REG_STATUS, 32'h4);
    chkReg(loadCnt, 32'h0);
    host.hostWrite(BOOT_HI_END, CMD_LOAD2);
    chkReg(loadCnt, 32'h1);
    chkReg({16'h0, loadBlock_r, loadPage_r}, {16'h0, 10'h005, 6'h3F});
    rdHost(16'h0000, 16'h0001);
    donePulse();
    rdReg(REG_STATUS, 32'h0);
    rdReg(REG_FLASH_ADDR, 32'h0300_0005);
    // Broken sequences fall back to ready without loading
    host.hostWrite(16'h0000, CMD_LOAD);
    host.hostWrite(16'h0000, 16'h1234);
    rdReg(REG_STATUS, 32'h0);
    // An outside write keeps the pending code; a boot read drops it
    host.hostWrite(16'h0000, CMD_LOAD);
    host.hostWrite(16'h0400, CMD_LOAD2);
    rdReg(REG_STATUS, 32'h4);
    host.hostWrite(16'h0000, CMD_LOAD2);
    chkReg(loadCnt, 32'h2);
    donePulse();
    host.hostWrite(16'h0000, CMD_LOAD);
    host.hostRead(16'h0000);
    host.hostWrite(16'h0000, CMD_LOAD2);
    chkReg(loadCnt, 32'h2);
    // Identification data, then ended by a write strobe
    apbXfer(1'b1, REG_FLASH_ADDR, 32'h0001_0007);
    host.hostWrite(BOOT_LO_END, CMD_ID);
    rdReg(REG_STATUS, 32'h2);
    rdHost(ID_OFS_MFR, MFR);
    rdHost(ID_OFS_DEV, DEV);
    rdHost(ID_OFS_WP, WP);
    host.hostWrite(16'h0400, 16'h0000);
    rdHost(16'h0000, 16'h1234);
    // Reset code restores defaults; next load starts at page zero
    apbXfer(1'b1, REG_BUF_SEL, 32'h0000_0102);
    host.hostWrite(BOOT_HI_BASE, CMD_RESET);
    chkReg(rstCnt, 32'h1);
    rdReg(REG_FLASH_ADDR, 32'h0);
    rdReg(REG_BUF_SEL, 32'h0);
    rdReg(REG_BOOT_IDX, 32'h0);
    host.hostWrite(16'h0000, CMD_LOAD);
    host.hostWrite(16'h0000, CMD_LOAD2);
    chkReg({16'h0, loadBlock_r, loadPage_r}, 32'h0);
    donePulse();
    rdReg(REG_FLASH_ADDR, 32'h0001_0000);
    report_and_stop();
  end
endmodule : test_boot_region_command_decoder
`default_nettype wire
